// ==== hw/adc_regs_pkg.sv ====
// Package: register map, field layout and reset values of the converter register bank
package adc_regs_pkg;

  // ------------------------------------------------------------
  // Register byte addresses (printed offsets are not all multiples of four,
  // so each printed offset is an index and the byte address is index * 4)
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_RESULT_LOW = 8'h50;   // Result low byte
  localparam logic [7:0] IDX_RESULT_HIGH = 8'h51;  // Result high byte
  localparam logic [7:0] IDX_CONV_CTRL = 8'h52;    // Conversion control
  localparam logic [7:0] IDX_BIAS_EN = 8'h53;      // Bias and stage enable
  localparam logic [7:0] IDX_RATE_STAGE2 = 8'h54;  // Sampling rate, second stage
  localparam logic [7:0] IDX_GAIN_13 = 8'h55;      // First and third stage gain
  localparam logic [7:0] IDX_OFFSET_3 = 8'h56;     // Third stage offset
  localparam logic [7:0] IDX_CHAN_REF = 8'h57;     // Channel and reference select
  localparam logic [7:0] IDX_MODE = 8'h70;         // Chip operating mode
  localparam logic [7:0] IDX_GPIO = 8'h40;         // Pin direction and drive value
  localparam int ADDR_W = 10;                      // Byte address width on the bus

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CC_START = 7;
  localparam int CC_NELC_HI = 6;
  localparam int CC_NELC_LO = 5;
  localparam int CC_OSR_HI = 4;
  localparam int CC_OSR_LO = 2;
  localparam int CC_REPEAT = 1;
  localparam int CR_BUSY = 7;
  localparam int CR_PRESET = 6;
  localparam int MD_SETTLED = 7;
  localparam int MD_RUNNING = 6;
  localparam int MD_CHOP_HI = 5;
  localparam int MD_CHOP_LO = 4;
  localparam int MD_FORCE_ON = 3;
  localparam int MD_FORCE_OFF = 2;
  localparam int MD_REF_OUT = 1;
  localparam int MD_REF_IN = 0;
  localparam int GP_DIR0 = 4;
  localparam int GP_OUT0 = 0;

  // ------------------------------------------------------------
  // Reset values of the writable parts
  // ------------------------------------------------------------
  localparam logic [7:0] RST_CONV_CTRL = 8'h28;    // Count 01, oversampling 010
  localparam logic [7:0] RST_BIAS_EN = 8'hF0;      // Both biases 11, stages off
  localparam logic [7:0] RST_RATE_STAGE2 = 8'h00;
  localparam logic [7:0] RST_GAIN_13 = 8'h0C;
  localparam logic [7:0] RST_OFFSET_3 = 8'h00;
  localparam logic [7:0] RST_CHAN_REF = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h04;         // Force-off set
  localparam logic [7:0] RST_GPIO = 8'h30;         // Both pins output, drive 0
  localparam logic [7:0] MASK_CONV_CTRL = 8'h7E;   // Start bit is not stored
  localparam logic [7:0] MASK_OFFSET_3 = 8'h7F;
  localparam logic [7:0] MASK_CHAN_REF = 8'h7F;    // Busy is read-only
  localparam logic [7:0] MASK_MODE = 8'h3F;        // Pump flags are read-only
  localparam logic [7:0] MASK_GPIO = 8'h33;

  // ------------------------------------------------------------
  // Reference chop encodings
  // ------------------------------------------------------------
  localparam logic [1:0] CHOP_LOW = 2'h0;
  localparam logic [1:0] CHOP_HIGH = 2'h1;
  localparam logic [1:0] CHOP_EVERY = 2'h2;
  localparam logic [1:0] CHOP_HALF = 2'h3;

  // ------------------------------------------------------------
  // Bus responses and timing
  // ------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int PUMP_SETTLE_NS = 1000;             // Pump settling time
  localparam int CLK_PERIOD_NS = 10;
  localparam int PUMP_SETTLE_CYC = (PUMP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PUMP_CNT_W = 8;

endpackage

// ==== hw/adc_control_mode_registers.sv ====
// Converter control and mode register bank behind an AXI4-Lite slave
module adc_control_mode_registers
  import adc_regs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [adc_regs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [adc_regs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic supply_low,
  input wire logic conv_done,
  input wire logic [15:0] conv_result,
  input wire logic elementary_tick,
  output logic conv_start_pulse,
  output logic [7:0] conv_control,
  output logic [7:0] bias_and_stage_enable,
  output logic [7:0] sample_rate_second_stage,
  output logic [7:0] first_third_stage_gain,
  output logic [7:0] third_stage_offset,
  output logic [6:0] channel_and_reference_select,
  output logic reference_chop,
  output logic pump_enable,
  output logic reference_to_first_pin,
  output logic reference_from_second_pin,
  output logic first_multi_pin_out,
  output logic first_multi_pin_oe
);
  import adc_regs_pkg::*;

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [7:0] conv_ctrl_ff;      // Count, oversampling, repeat
  logic [7:0] bias_en_ff;        // Biases and stage enables
  logic [7:0] rate_stage2_ff;    // Sampling rate, second stage
  logic [7:0] gain_13_ff;        // Gains
  logic [7:0] offset_3_ff;       // Third stage offset
  logic [7:0] chan_ref_ff;       // Preset, channel, reference source
  logic [7:0] mode_ff;           // Writable mode bits
  logic [7:0] gpio_ff;           // Pin direction and drive
  logic [15:0] result_ff;        // Last conversion result
  logic busy_ff;                 // Conversion in progress
  logic chop_ff;                 // Reference chop state
  logic chop_half_ff;            // Divides chop toggles by two
  logic pump_on_ff;              // Pump running
  logic settled_ff;              // Pump output good
  logic [PUMP_CNT_W-1:0] settle_cnt_ff;

  // Write channel holding
  logic aw_got_ff;
  logic w_got_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic wr_fire;
  logic [7:0] wr_idx;
  logic wr_mapped;
  logic wr_lane0;

  // ------------------------------------------------------------
  // Write address and data capture, either order
  // ------------------------------------------------------------
  // Each channel is taken once and held until the write fires and raises the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      aw_addr_ff <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_ff <= 1'b0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_ff <= 1'b1;
      w_data_ff <= s_axi_wdata;
      w_strb_ff <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_got_ff <= 1'b0;
    end
  end

  // Ready only while the slot is empty and no response pends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_got_ff && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid
                       && !wr_fire;
      s_axi_wready <= !w_got_ff && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid
                      && !wr_fire;
    end
  end

  assign wr_fire = aw_got_ff && w_got_ff && !s_axi_bvalid;
  assign wr_idx = aw_addr_ff[ADDR_W-1:2];
  assign wr_lane0 = w_strb_ff[0];
  assign wr_mapped = (wr_idx == IDX_CONV_CTRL) || (wr_idx == IDX_BIAS_EN) ||
                     (wr_idx == IDX_RATE_STAGE2) || (wr_idx == IDX_GAIN_13) ||
                     (wr_idx == IDX_OFFSET_3) || (wr_idx == IDX_CHAN_REF) ||
                     (wr_idx == IDX_MODE) || (wr_idx == IDX_GPIO) ||
                     (wr_idx == IDX_RESULT_LOW) || (wr_idx == IDX_RESULT_HIGH);

  // Response: unmapped addresses answer with a slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Writable registers; unused bits are masked off
  // ------------------------------------------------------------
  // Only lane 0 carries the 8-bit register; upper lanes are ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_ctrl_ff <= RST_CONV_CTRL;
      bias_en_ff <= RST_BIAS_EN;
      rate_stage2_ff <= RST_RATE_STAGE2;
      gain_13_ff <= RST_GAIN_13;
      offset_3_ff <= RST_OFFSET_3;
      chan_ref_ff <= RST_CHAN_REF;
      mode_ff <= RST_MODE;
      gpio_ff <= RST_GPIO;
    end else if (wr_fire && wr_lane0) begin
      case (wr_idx)
        IDX_CONV_CTRL: conv_ctrl_ff <= w_data_ff[7:0] & MASK_CONV_CTRL;
        IDX_BIAS_EN: bias_en_ff <= w_data_ff[7:0];
        IDX_RATE_STAGE2: rate_stage2_ff <= w_data_ff[7:0];
        IDX_GAIN_13: gain_13_ff <= w_data_ff[7:0];
        IDX_OFFSET_3: offset_3_ff <= w_data_ff[7:0] & MASK_OFFSET_3;
        IDX_CHAN_REF: chan_ref_ff <= w_data_ff[7:0] & MASK_CHAN_REF;
        IDX_MODE: mode_ff <= w_data_ff[7:0] & MASK_MODE;
        IDX_GPIO: gpio_ff <= w_data_ff[7:0] & MASK_GPIO;
        default: begin
          // Result bytes and unmapped words ignore writes
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Conversion start and activity
  // ------------------------------------------------------------
  logic start_wr;
  assign start_wr = wr_fire && wr_lane0 && (wr_idx == IDX_CONV_CTRL) && w_data_ff[CC_START];

  // Start pulses once per write; repeat mode relaunches after each result
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_start_pulse <= 1'b0;
    end else begin
      conv_start_pulse <= start_wr ||
                          (conv_done && busy_ff && conv_ctrl_ff[CC_REPEAT]);
    end
  end

  // Busy from start until the last result with repeat off; a new start wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_ff <= 1'b0;
    end else if (start_wr) begin
      busy_ff <= 1'b1;
    end else if (conv_done && !conv_ctrl_ff[CC_REPEAT]) begin
      busy_ff <= 1'b0;
    end
  end

  // Result captured on each completion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_ff <= '0;
    end else if (conv_done) begin
      result_ff <= conv_result;
    end
  end

  // ------------------------------------------------------------
  // Reference chopping
  // ------------------------------------------------------------
  // Toggles only during a conversion, on the elementary-conversion tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chop_ff <= 1'b0;
      chop_half_ff <= 1'b0;
    end else begin
      case (mode_ff[MD_CHOP_HI:MD_CHOP_LO])
        CHOP_LOW: chop_ff <= 1'b0;
        CHOP_HIGH: chop_ff <= 1'b1;
        CHOP_EVERY: begin
          if (elementary_tick && busy_ff) begin
            chop_ff <= !chop_ff;
          end
        end
        CHOP_HALF: begin
          if (elementary_tick && busy_ff) begin
            chop_half_ff <= !chop_half_ff;
            if (chop_half_ff) begin
              chop_ff <= !chop_ff;
            end
          end
        end
        default: chop_ff <= 1'b0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Charge pump control and settling
  // ------------------------------------------------------------
  logic nxt_pump_on;
  always_comb begin
    if (mode_ff[MD_FORCE_ON]) begin
      nxt_pump_on = 1'b1;
    end else if (mode_ff[MD_FORCE_OFF]) begin
      nxt_pump_on = 1'b0;
    end else begin
      nxt_pump_on = supply_low;
    end
  end

  // Settled stays one while the pump is off: supply is then adequate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pump_on_ff <= 1'b0;
      settled_ff <= 1'b1;
      settle_cnt_ff <= '0;
    end else begin
      pump_on_ff <= nxt_pump_on;
      if (nxt_pump_on && !pump_on_ff) begin
        settled_ff <= 1'b0;
        settle_cnt_ff <= PUMP_CNT_W'(PUMP_SETTLE_CYC);
      end else if (!nxt_pump_on) begin
        settled_ff <= 1'b1;
        settle_cnt_ff <= '0;
      end else if (settle_cnt_ff != '0) begin
        settle_cnt_ff <= settle_cnt_ff - 1'b1;
        settled_ff <= (settle_cnt_ff == PUMP_CNT_W'(1));
      end
    end
  end

  // ------------------------------------------------------------
  // Read channel
  // ------------------------------------------------------------
  logic [7:0] rd_byte;
  logic rd_mapped;
  logic [7:0] rd_idx;
  assign rd_idx = s_axi_araddr[ADDR_W-1:2];

  always_comb begin
    rd_mapped = 1'b1;
    case (rd_idx)
      IDX_RESULT_LOW: rd_byte = result_ff[7:0];
      IDX_RESULT_HIGH: rd_byte = result_ff[15:8];
      IDX_CONV_CTRL: rd_byte = conv_ctrl_ff;
      IDX_BIAS_EN: rd_byte = bias_en_ff;
      IDX_RATE_STAGE2: rd_byte = rate_stage2_ff;
      IDX_GAIN_13: rd_byte = gain_13_ff;
      IDX_OFFSET_3: rd_byte = offset_3_ff;
      IDX_CHAN_REF: rd_byte = {busy_ff, chan_ref_ff[6:0]};
      IDX_MODE: rd_byte = {settled_ff, pump_on_ff, mode_ff[5:0]};
      IDX_GPIO: rd_byte = gpio_ff;
      default: begin
        rd_byte = 8'h00;
        rd_mapped = 1'b0;
      end
    endcase
  end

  // One read at a time; data sampled at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Outputs toward the converter and pins, all registered
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_control <= RST_CONV_CTRL;
      bias_and_stage_enable <= RST_BIAS_EN;
      sample_rate_second_stage <= RST_RATE_STAGE2;
      first_third_stage_gain <= RST_GAIN_13;
      third_stage_offset <= RST_OFFSET_3;
      channel_and_reference_select <= RST_CHAN_REF[6:0];
      reference_chop <= 1'b0;
      pump_enable <= 1'b0;
      reference_to_first_pin <= 1'b0;
      reference_from_second_pin <= 1'b0;
      first_multi_pin_out <= 1'b0;
      first_multi_pin_oe <= 1'b0;
    end else begin
      conv_control <= conv_ctrl_ff;
      bias_and_stage_enable <= bias_en_ff;
      sample_rate_second_stage <= rate_stage2_ff;
      first_third_stage_gain <= gain_13_ff;
      third_stage_offset <= offset_3_ff;
      channel_and_reference_select <= chan_ref_ff[6:0];
      reference_chop <= chop_ff;
      pump_enable <= nxt_pump_on;
      reference_to_first_pin <= mode_ff[MD_REF_OUT];
      reference_from_second_pin <= mode_ff[MD_REF_IN];
      first_multi_pin_out <= gpio_ff[GP_OUT0];
      first_multi_pin_oe <= gpio_ff[GP_DIR0] && !mode_ff[MD_REF_OUT];
    end
  end

endmodule

// ==== bench/conv_model.sv ====
// Converter datapath stand-in that answers start pulses with ticks and a result
module conv_model (
  input wire logic aclk,
  input wire logic conv_start_pulse,
  output logic elementary_tick,
  output logic conv_done,
  output logic [15:0] conv_result
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Conversion sequence
  // ----------------------------------------
  localparam logic [15:0] RESULT = 16'hA5C3; // Fixed sample value
  int cnt = 0; // Cycles left in the running conversion
  initial begin
    elementary_tick = 1'b0;
    conv_done = 1'b0;
    conv_result = ~RESULT;
  end
  // Four ticks eight cycles apart, then one done pulse; the result bus
  // shows the inverse outside the done cycle so a stale capture is seen
  always @(posedge aclk) begin
    if (conv_start_pulse) cnt <= 40;
    else if (cnt > 0) cnt <= cnt - 1;
    elementary_tick <= (cnt > 1) && (cnt < 40) && (cnt % 8 == 0);
    conv_done <= (cnt == 2);
    conv_result <= (cnt == 2) ? RESULT : ~RESULT;
  end
endmodule

// ==== bench/adc_regs_properties.sv ====
// Port-level assertions for the converter register bank
module adc_regs_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic conv_done,
  input wire logic conv_start_pulse,
  input wire logic [7:0] conv_control,
  input wire logic [7:0] bias_and_stage_enable,
  input wire logic [7:0] sample_rate_second_stage,
  input wire logic [7:0] third_stage_offset,
  input wire logic reference_to_first_pin,
  input wire logic first_multi_pin_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Clocking and sequences
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both halves of a write taken at one edge
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Write answer offered but not yet taken
  sequence resp_waiting;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_reset_fields:
    assert property ($rose(aresetn) |-> conv_control[6:2] == 5'h0A
      && bias_and_stage_enable == 8'hF0 && sample_rate_second_stage[7:6] == 2'h0)
    else $error("field reset value wrong");
  chk_start_single:
    assert property (conv_start_pulse |=> !conv_start_pulse)
    else $error("start pulse longer than one cycle");
  chk_start_cause:
    assert property (conv_start_pulse |-> s_axi_bvalid || $past(conv_done))
    else $error("start pulse without write or repeat");
  chk_unused_bits:
    assert property (conv_control[0] == 1'b0 && third_stage_offset[7] == 1'b0)
    else $error("unused bit set");
  chk_pin_release:
    assert property (reference_to_first_pin && $past(reference_to_first_pin)
      |-> !first_multi_pin_oe)
    else $error("pin driven while routed to reference");
  chk_rdata_upper:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  chk_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_write_answer:
    assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  chk_resp_hold:
    assert property (resp_waiting |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
endmodule

bind adc_control_mode_registers adc_regs_checker adc_regs_checker_inst (.*);

// ==== bench/adc_control_mode_registers_bench.sv ====
// Self-checking bench for the converter register bank
module adc_control_mode_registers_bench import adc_regs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'h1; // Only lane 0 carries a register
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, supply_low = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic conv_done, elementary_tick, conv_start_pulse, reference_chop, pump_enable;
  logic [15:0] conv_result;
  logic [7:0] conv_control, bias_and_stage_enable, sample_rate_second_stage;
  logic [7:0] first_third_stage_gain, third_stage_offset;
  logic [6:0] channel_and_reference_select;
  logic reference_to_first_pin, reference_from_second_pin;
  logic first_multi_pin_out, first_multi_pin_oe;
  int n_errors = 0, total_checks = 0, n_toggle = 0, n_start = 0;
  // Reset table, then write table with expected readback
  logic [7:0] ri [9] = '{8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h70};
  logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h28, 8'hF0, 8'h00, 8'h0C, 8'h00, 8'h00, 8'h84};
  logic [7:0] wi [6] = '{8'h50, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57};
  logic [7:0] wv [6] = '{8'hFF, 8'h5A, 8'hC3, 8'h8C, 8'hFF, 8'hFF};
  logic [7:0] we [6] = '{8'h00, 8'h5A, 8'hC3, 8'h8C, 8'h7F, 8'h7F};
  int tog [4] = '{0, 0, 4, 2}; // Chop changes over four ticks per code
  adc_control_mode_registers adc_control_mode_registers_inst (.*);
  conv_model conv_model_inst (.aclk, .conv_start_pulse, .elementary_tick, .conv_done,
    .conv_result);
  // ----------------------------------------
  // Clock and monitors
  // ----------------------------------------
  always #5 aclk = ~aclk;
  always @(reference_chop) n_toggle++;
  always @(posedge aclk) if (conv_start_pulse === 1'b1) n_start++;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // Both write channels offered together, each released once taken;
  // a nonzero lag keeps bready low that many edges so the answer must wait
  task automatic wr_chk(input logic [7:0] idx, input logic [7:0] d,
    input logic [1:0] er = RESP_OKAY, input int lag = 0);
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && s_axi_awready !== 1'b1)
      || (s_axi_wvalid && s_axi_wready !== 1'b1));
    if (lag > 0) begin
      repeat (lag) @(posedge aclk);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b0;
    check($sformatf("write resp %0h", idx), er, s_axi_bresp);
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e,
    input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check($sformatf("read resp %0h", idx), er, s_axi_rresp);
    check($sformatf("read data %0h", idx), {24'h0, e}, s_axi_rdata);
  endtask
  // Pin outputs lag the register by a cycle, so let two edges pass
  task automatic pins(input logic oe, input logic rf, input logic rs);
    repeat (2) @(posedge aclk);
    check("pin enable", oe, first_multi_pin_oe);
    check("reference out", rf, reference_to_first_pin);
    check("reference in", rs, reference_from_second_pin);
  endtask
  task automatic wrap_up;
    if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    foreach (ri[i]) rd_chk(ri[i], rv[i]);
    rd_chk(8'h20, 8'h00, RESP_SLVERR);
    wr_chk(8'h20, 8'hFF, RESP_SLVERR, 3);
    foreach (wi[i]) begin
      wr_chk(wi[i], wv[i]);
      rd_chk(wi[i], we[i]);
    end
    check("bias out", 8'h5A, bias_and_stage_enable);
    check("channel out", 7'h7F, channel_and_reference_select);
    check("rate out", 8'hC3, sample_rate_second_stage);
    check("gain out", 8'h8C, first_third_stage_gain);
    check("offset out", 8'h7F, third_stage_offset);
    // Start bit and unused bit never read back
    wr_chk(8'h52, 8'hFD);
    rd_chk(8'h52, 8'h7C);
    check("control out", 8'h7C, conv_control);
    rd_chk(8'h57, 8'hFF);
    repeat (60) @(posedge aclk);
    // Every chop code over one conversion each
    foreach (tog[c]) begin
      wr_chk(8'h70, {2'h0, c[1:0], 4'h4});
      wr_chk(8'h52, 8'hA8);
      n_toggle = 0;
      repeat (60) @(posedge aclk);
      check("chop changes", tog[c], n_toggle);
      if (c < 2) check("chop level", c[0], reference_chop);
      rd_chk(8'h57, 8'h7F);
      rd_chk(8'h50, 8'hC3);
      rd_chk(8'h51, 8'hA5);
    end
    n_start = 0;
    wr_chk(8'h52, 8'hAA);
    repeat (100) @(posedge aclk);
    check("repeat runs", 1, n_start >= 2);
    wr_chk(8'h52, 8'h28);
    repeat (60) @(posedge aclk);
    n_start = 0;
    repeat (60) @(posedge aclk);
    check("repeat stops", 0, n_start);
    // Pump forcing, settling and automatic start
    wr_chk(8'h70, 8'h08);
    rd_chk(8'h70, 8'h48);
    check("pump on", 1, pump_enable);
    repeat (110) @(posedge aclk);
    rd_chk(8'h70, 8'hC8);
    wr_chk(8'h70, 8'h0C);
    rd_chk(8'h70, 8'hCC);
    wr_chk(8'h70, 8'h00);
    rd_chk(8'h70, 8'h80);
    supply_low <= 1'b1;
    repeat (3) @(posedge aclk);
    rd_chk(8'h70, 8'h40);
    check("pump auto", 1, pump_enable);
    supply_low <= 1'b0;
    wr_chk(8'h70, 8'h04);
    rd_chk(8'h70, 8'h84);
    check("pump off", 0, pump_enable);
    // Multi-function pin routing
    rd_chk(8'h40, 8'h30);
    wr_chk(8'h40, 8'h31);
    pins(1'b1, 1'b0, 1'b0);
    check("pin value", 1, first_multi_pin_out);
    wr_chk(8'h70, 8'h06);
    pins(1'b0, 1'b1, 1'b0);
    wr_chk(8'h70, 8'h05);
    pins(1'b1, 1'b0, 1'b1);
    wr_chk(8'h40, 8'h01);
    pins(1'b0, 1'b0, 1'b1);
    wrap_up();
  end
  // Hang guard, well beyond the roughly one thousand cycles the tests need
  initial begin
    repeat (5000) @(posedge aclk);
    n_errors++;
    wrap_up();
  end
endmodule
